// file: aat_datapath.sv
// Accumulator, timer-register and miscellaneous instruction execution datapath.
//
// Contract
// - AND with register nibble; carry is A3 and operand bit 3.
// - AND with ROM nibble at page and pointer; carry is A3 and ROM bit.
// - ROM high form uses bits 7..4, low form 3..0; rest ignored.
// - AND with immediate nibble; carry is A3 and immediate bit 3.
// - OR with register, ROM or immediate; carry always cleared.
// - XOR with register, ROM or immediate; carry is A3 and operand bit 3.
// - Increment modulo 16; carry set when the result is zero.
// - Rotate left; old bit 3 goes to bit 0 and to carry.
// - Rotate-or-zero-reset raises internal reset on zero, else rotates.
// - Port read loads a port nibble into A and clears carry.
// - Timer nibble reads use FFFF and FEFF and clear carry.
// - Modulo register nibble reads use FFF6/FEF6, FFF7/FEF7, clear carry.
// - Accumulator writes to modulo or timer nibbles clear carry.
// - E6FF loads the whole timer from the 10-bit immediate.
// - E6F6 and E6F7 load the modulo registers from the 10-bit immediate.
// - Table loads copy the full ROM word into modulo registers or timer.
// - E2F1 with a condition nibble enters standby mode.
// - Status compare sets match on equality with immediate or register.
// - FAF3 sets carry when A is F, else clears; A unchanged.
// - ROM address is page control above the eight-bit pointer pair.
// - High timer nibble is bits 9..6, low nibble bits 5..2.
`timescale 1ns/10ps
`default_nettype none
module aat_datapath (
  // Clock, enable and reset.
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  // Instruction stream.
  input  wire aat_pkg::aat_instr_type i_instr,
  // Program memory and page control.
  input  wire logic [9:0]            i_rom_word,
  input  wire logic [3:0]            i_rom_page_ctrl,
  // Port pins, internal statuses and standby release.
  input  wire logic [7:0][3:0]       i_port_in,
  input  wire logic [3:0]            i_status,
  input  wire logic                  i_wake,
  // Accumulator and flags.
  output logic [3:0]                 o_acc,
  output logic                       o_carry_bit,
  output logic                       o_match,
  // Timer and modulo registers.
  output aat_pkg::aat_tmr_type       o_tmr,
  // Sequencing outputs.
  output logic [11:0]                o_rom_addr,
  output logic                       o_standby,
  output logic [3:0]                 o_standby_cond,
  output logic                       o_internal_reset,
  output logic                       o_done
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Picks the high or low nibble of a 10-bit timer or modulo value.
  function automatic logic [3:0] get_nib(input logic [9:0] val, input logic hi);
    get_nib = hi ? val[aat_pkg::NIB_HI_LSB +: 4] : val[aat_pkg::NIB_LO_LSB +: 4];
  endfunction

  // Replaces one nibble of a 10-bit value; the two lowest bits are kept.
  function automatic logic [9:0] set_nib(input logic [9:0] val, input logic hi, input logic [3:0] nib);
    logic [9:0] res;
    res = val;
    if (hi) begin
      res[aat_pkg::NIB_HI_LSB +: 4] = nib;
    end else begin
      res[aat_pkg::NIB_LO_LSB +: 4] = nib;
    end
    set_nib = res;
  endfunction

  // Maps port numbers 0, 1, 3 and 4 onto slots 0 to 3.
  function automatic logic [1:0] port_slot(input logic [2:0] num);
    port_slot = (num > 3'd2) ? 2'(num - 3'd1) : num[1:0];
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [3:0]            regs [0:31];
  aat_pkg::aat_mode_type mode;
  logic [15:0]           w1;
  logic [7:0]            op_cls;
  logic [7:0]            src;
  logic [4:0]            reg_idx;
  logic                  exec;
  logic [3:0]            operand;
  logic                  opnd_ok;
  logic [3:0]            next_acc;
  logic                  next_carry;
  logic                  rotz_hit;

  // Split the first word into its operation class and operand source.
  assign w1       = i_instr.word1;
  assign op_cls   = w1[15:8] & aat_pkg::CLASS_MASK;
  assign src      = w1[7:0];
  assign reg_idx  = {~w1[8], src[3:0]};
  assign exec     = i_ce & i_instr.valid & (mode == aat_pkg::MODE_RUN);
  assign rotz_hit = (w1 == aat_pkg::C_ROTZ) && (o_acc == 4'h0);

  // ****************************************
  // Operand selection
  // ****************************************

  // Register, ROM, immediate or port nibble; ROM bits 8 and 9 never reach it.
  always_comb begin
    operand = 4'h0;
    opnd_ok = 1'b0;
    if (src[7:4] == aat_pkg::SRC_REG) begin
      operand = regs[reg_idx];
      opnd_ok = 1'b1;
    end else if (src == aat_pkg::SRC_ROM) begin
      operand = w1[8] ? i_rom_word[3:0] : i_rom_word[aat_pkg::ROM_HI_LSB +: 4];
      opnd_ok = 1'b1;
    end else if (src == aat_pkg::SRC_IMM) begin
      operand = i_instr.word2[3:0];
      opnd_ok = 1'b1;
    end else if (src >= aat_pkg::SRC_PORT_LO && src <= aat_pkg::SRC_PORT_HI && src[2:0] != 3'd2) begin
      operand = i_port_in[{~w1[8], port_slot(src[2:0])}];
      opnd_ok = 1'b1;
    end
  end

  // ****************************************
  // Accumulator and carry arithmetic
  // ****************************************

  // Exact codes are tested before the class decode because several share a class byte.
  always_comb begin
    next_acc   = o_acc;
    next_carry = o_carry_bit;
    if (w1 == aat_pkg::C_INC) begin
      next_acc   = o_acc + 4'h1;
      next_carry = (o_acc == 4'hf);
    end else if (w1 == aat_pkg::C_ROT || (w1 == aat_pkg::C_ROTZ && !rotz_hit)) begin
      next_acc   = {o_acc[2:0], o_acc[aat_pkg::ACC_MSB]};
      next_carry = o_acc[aat_pkg::ACC_MSB];
    end else if (w1 == aat_pkg::C_ONES) begin
      next_carry = (o_acc == 4'hf);
    end else if (w1 == aat_pkg::C_RD_TLO || w1 == aat_pkg::C_RD_THI) begin
      next_acc   = get_nib(o_tmr.timer, ~w1[8]);
      next_carry = 1'b0;
    end else if (w1 == aat_pkg::C_RD_M0LO || w1 == aat_pkg::C_RD_M0HI) begin
      next_acc   = get_nib(o_tmr.mod0, ~w1[8]);
      next_carry = 1'b0;
    end else if (w1 == aat_pkg::C_RD_M1LO || w1 == aat_pkg::C_RD_M1HI) begin
      next_acc   = get_nib(o_tmr.mod1, ~w1[8]);
      next_carry = 1'b0;
    end else if (w1 == aat_pkg::C_WR_TLO || w1 == aat_pkg::C_WR_THI || w1 == aat_pkg::C_WR_M0LO
                 || w1 == aat_pkg::C_WR_M0HI || w1 == aat_pkg::C_WR_M1LO || w1 == aat_pkg::C_WR_M1HI) begin
      next_carry = 1'b0;
    end else if (opnd_ok && op_cls == aat_pkg::CLS_MOV) begin
      next_acc   = operand;
      next_carry = 1'b0;
    end else if (opnd_ok && op_cls == aat_pkg::CLS_AND) begin
      next_acc   = o_acc & operand;
      next_carry = o_acc[aat_pkg::ACC_MSB] & operand[3];
    end else if (opnd_ok && op_cls == aat_pkg::CLS_OR) begin
      next_acc   = o_acc | operand;
      next_carry = 1'b0;
    end else if (opnd_ok && op_cls == aat_pkg::CLS_XOR) begin
      next_acc   = o_acc ^ operand;
      next_carry = o_acc[aat_pkg::ACC_MSB] & operand[3];
    end
  end

  // Accumulator and carry registers.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_acc       <= aat_pkg::ACC_RST;
      o_carry_bit <= 1'b0;
    end else if (exec) begin
      o_acc       <= next_acc;
      o_carry_bit <= next_carry;
    end
  end

  // ****************************************
  // Data registers and ROM address
  // ****************************************

  // Stores from the accumulator; the pointer pair lives at R00 and R10.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < aat_pkg::REG_COUNT; i++) begin
        regs[i] <= 4'h0;
      end
    end else if (exec && op_cls == aat_pkg::CLS_STORE && src[7:4] == aat_pkg::SRC_REG) begin
      regs[reg_idx] <= o_acc;
    end
  end

  // Registered so the address is stable for a whole cycle; a pointer change shows one cycle later.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rom_addr <= aat_pkg::ROM_ADR_RST;
    end else if (i_ce) begin
      o_rom_addr <= {i_rom_page_ctrl, regs[aat_pkg::PTR_HI_IDX], regs[aat_pkg::PTR_LO_IDX]};
    end
  end

  // ****************************************
  // Timer and modulo registers
  // ****************************************

  // Immediate, table and nibble loads of the timer and both modulo registers.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_tmr <= '{timer: aat_pkg::WORD_RST, mod0: aat_pkg::WORD_RST, mod1: aat_pkg::WORD_RST};
    end else if (exec) begin
      unique case (w1)
        aat_pkg::C_LD_T:    o_tmr.timer <= i_instr.word2;
        aat_pkg::C_LD_M0:   o_tmr.mod0  <= i_instr.word2;
        aat_pkg::C_LD_M1:   o_tmr.mod1  <= i_instr.word2;
        aat_pkg::C_TB_T:    o_tmr.timer <= i_rom_word;
        aat_pkg::C_TB_M0:   o_tmr.mod0  <= i_rom_word;
        aat_pkg::C_TB_M1:   o_tmr.mod1  <= i_rom_word;
        aat_pkg::C_WR_TLO,
        aat_pkg::C_WR_THI:  o_tmr.timer <= set_nib(o_tmr.timer, w1 == aat_pkg::C_WR_THI, o_acc);
        aat_pkg::C_WR_M0LO,
        aat_pkg::C_WR_M0HI: o_tmr.mod0  <= set_nib(o_tmr.mod0, ~w1[8], o_acc);
        aat_pkg::C_WR_M1LO,
        aat_pkg::C_WR_M1HI: o_tmr.mod1  <= set_nib(o_tmr.mod1, ~w1[8], o_acc);
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Status, standby and sequencing
  // ****************************************

  // Match flag compares the internal statuses with the operand nibble.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_match <= 1'b0;
    end else if (exec && w1 == aat_pkg::C_STATUS_COMPARE_I) begin
      o_match <= (i_status == i_instr.word2[3:0]);
    end else if (exec && w1[15:8] == aat_pkg::C_STATUS_COMPARE_R && src[7:4] == aat_pkg::SRC_REG) begin
      o_match <= (i_status == regs[{1'b0, src[3:0]}]);
    end
  end

  // Standby holds off all execution until the release input is seen.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode           <= aat_pkg::MODE_RUN;
      o_standby_cond <= 4'h0;
    end else if (i_ce) begin
      unique case (mode)
        aat_pkg::MODE_RUN: begin
          if (exec && w1 == aat_pkg::C_STANDBY) begin
            mode           <= aat_pkg::MODE_STANDBY;
            o_standby_cond <= i_instr.word2[3:0];
          end
        end
        aat_pkg::MODE_STANDBY: begin
          if (i_wake) begin
            mode <= aat_pkg::MODE_RUN;
          end
        end
        default: begin
          mode <= aat_pkg::MODE_RUN;
        end
      endcase
    end
  end

  assign o_standby = mode[1];

  // One-cycle completion and internal reset pulses.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_done           <= 1'b0;
      o_internal_reset <= 1'b0;
    end else if (i_ce) begin
      o_done           <= exec;
      o_internal_reset <= exec && rotz_hit;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_and_carry;
    exec && opnd_ok && op_cls == aat_pkg::CLS_AND && src != 8'hff
      |=> o_acc == ($past(o_acc) & $past(operand)) && o_carry_bit == ($past(o_acc[3]) & $past(operand[3]));
  endproperty
  a_and_carry: assert property (p_and_carry) else $error("AND result or carry wrong.");

  property p_or_clear;
    exec && opnd_ok && op_cls == aat_pkg::CLS_OR && w1 != aat_pkg::C_ROT |=> !o_carry_bit;
  endproperty
  a_or_clear: assert property (p_or_clear) else $error("OR left carry set.");

  property p_xor;
    exec && opnd_ok && op_cls == aat_pkg::CLS_XOR && w1 != aat_pkg::C_WR_THI && w1 != aat_pkg::C_INC
      |=> o_acc == ($past(o_acc) ^ $past(operand)) && o_carry_bit == ($past(o_acc[3]) & $past(operand[3]));
  endproperty
  a_xor: assert property (p_xor) else $error("XOR result or carry wrong.");

  property p_inc;
    exec && w1 == aat_pkg::C_INC |=> o_acc == 4'($past(o_acc) + 4'h1) && o_carry_bit == (o_acc == 4'h0);
  endproperty
  a_inc: assert property (p_inc) else $error("Increment wrong.");

  property p_rot;
    exec && w1 == aat_pkg::C_ROT |=> o_acc == {$past(o_acc[2:0]), $past(o_acc[3])} && o_carry_bit == $past(o_acc[3]);
  endproperty
  a_rot: assert property (p_rot) else $error("Rotate wrong.");

  property p_rotz;
    // A second zero rotate right behind the first legally keeps the pulse high.
    exec && rotz_hit |=> o_internal_reset && o_acc == 4'h0
      ##1 !o_internal_reset || !$past(i_ce) || ($past(exec) && $past(rotz_hit));
  endproperty
  a_rotz: assert property (p_rotz) else $error("Zero rotate did not pulse reset.");

  property p_tmr_read;
    exec && w1 == aat_pkg::C_RD_THI |=> o_acc == $past(o_tmr.timer[9:6]) && !o_carry_bit;
  endproperty
  a_tmr_read: assert property (p_tmr_read) else $error("Timer high read wrong.");

  property p_tmr_load;
    exec && w1 == aat_pkg::C_LD_T |=> o_tmr.timer == $past(i_instr.word2);
  endproperty
  a_tmr_load: assert property (p_tmr_load) else $error("Timer load wrong.");

  property p_ones;
    exec && w1 == aat_pkg::C_ONES |=> o_carry_bit == ($past(o_acc) == 4'hf) && $stable(o_acc);
  endproperty
  a_ones: assert property (p_ones) else $error("All-ones test wrong.");

  property p_standby;
    exec && w1 == aat_pkg::C_STANDBY |=> o_standby && o_standby_cond == $past(i_instr.word2[3:0]);
  endproperty
  a_standby: assert property (p_standby) else $error("Standby not entered.");

  property p_done;
    exec |=> o_done;
  endproperty
  a_done: assert property (p_done) else $error("Instruction did not complete.");

  c_rotz_reset: cover property (exec && rotz_hit ##1 o_internal_reset);
  c_standby_wake: cover property (o_standby ##[1:20] !o_standby);
  c_table_load: cover property (exec && w1 == aat_pkg::C_TB_M1);
  c_match: cover property (exec && w1 == aat_pkg::C_STATUS_COMPARE_I ##1 o_match);

endmodule
`default_nettype wire

// file: aat_pkg.sv
// Constants and types for the accumulator, timer-register and miscellaneous instruction datapath.
`default_nettype none
package aat_pkg;

  // ****************************************
  // Widths and field positions
  // ****************************************
  localparam int unsigned NIB_W       = 4;
  localparam int unsigned WORD_W      = 10;
  localparam int unsigned CODE_W      = 16;
  localparam int unsigned ROM_ADDR_W  = 12;
  localparam int unsigned REG_COUNT   = 32;
  localparam int unsigned PORT_COUNT  = 8;
  localparam int unsigned ACC_MSB     = 3;
  localparam int unsigned NIB_HI_LSB  = 6;
  localparam int unsigned NIB_LO_LSB  = 2;
  localparam int unsigned ROM_HI_LSB  = 4;
  localparam logic [4:0]  PTR_LO_IDX  = 5'h00;
  localparam logic [4:0]  PTR_HI_IDX  = 5'h10;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0]  ACC_RST     = 4'h0;
  localparam logic [9:0]  WORD_RST    = 10'h000;
  localparam logic [11:0] ROM_ADR_RST = 12'h000;

  // ****************************************
  // Operation classes and operand sources
  // ****************************************
  localparam logic [7:0] CLASS_MASK  = 8'hfe;
  localparam logic [7:0] CLS_MOV     = 8'hfe;
  localparam logic [7:0] CLS_AND     = 8'hfa;
  localparam logic [7:0] CLS_OR      = 8'hfc;
  localparam logic [7:0] CLS_XOR     = 8'hf4;
  localparam logic [7:0] CLS_STORE   = 8'he4;
  localparam logic [3:0] SRC_REG     = 4'he;
  localparam logic [7:0] SRC_ROM     = 8'hf0;
  localparam logic [7:0] SRC_IMM     = 8'hf1;
  localparam logic [7:0] SRC_PORT_LO = 8'hf8;
  localparam logic [7:0] SRC_PORT_HI = 8'hfc;

  // ****************************************
  // Exact first-word codes
  // ****************************************
  localparam logic [15:0] C_INC     = 16'hf4f3;
  localparam logic [15:0] C_ROT     = 16'hfcf3;
  localparam logic [15:0] C_ROTZ    = 16'hfef3;
  localparam logic [15:0] C_ONES    = 16'hfaf3;
  localparam logic [15:0] C_RD_TLO  = 16'hffff;
  localparam logic [15:0] C_RD_THI  = 16'hfeff;
  localparam logic [15:0] C_RD_M0LO = 16'hfff6;
  localparam logic [15:0] C_RD_M0HI = 16'hfef6;
  localparam logic [15:0] C_RD_M1LO = 16'hfff7;
  localparam logic [15:0] C_RD_M1HI = 16'hfef7;
  localparam logic [15:0] C_WR_TLO  = 16'he5ff;
  localparam logic [15:0] C_WR_THI  = 16'hf4ff;
  localparam logic [15:0] C_WR_M0LO = 16'he5f6;
  localparam logic [15:0] C_WR_M0HI = 16'he4f6;
  localparam logic [15:0] C_WR_M1LO = 16'he5f7;
  localparam logic [15:0] C_WR_M1HI = 16'he4f7;
  localparam logic [15:0] C_LD_T    = 16'he6ff;
  localparam logic [15:0] C_LD_M0   = 16'he6f6;
  localparam logic [15:0] C_LD_M1   = 16'he6f7;
  localparam logic [15:0] C_TB_T    = 16'he7ff;
  localparam logic [15:0] C_TB_M0   = 16'he7f6;
  localparam logic [15:0] C_TB_M1   = 16'he7f7;
  localparam logic [15:0] C_STANDBY = 16'he2f1;
  localparam logic [15:0] C_STATUS_COMPARE_I  = 16'he3f1;
  localparam logic [7:0]  C_STATUS_COMPARE_R  = 8'he3;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [15:0] word1;
    logic [9:0]  word2;
  } aat_instr_type;

  typedef struct packed {
    logic [9:0] timer;
    logic [9:0] mod0;
    logic [9:0] mod1;
  } aat_tmr_type;

  typedef enum logic [1:0] {
    MODE_RUN     = 2'b01,
    MODE_STANDBY = 2'b10
  } aat_mode_type;

endpackage
`default_nettype wire

// file: test_accumulator_alu_timer_ops.sv
// Self-checking testbench for the accumulator, timer-register and miscellaneous instruction datapath.
`timescale 1ns/10ps
`default_nettype none
module test_accumulator_alu_timer_ops;

  // ****************************************
  // Stimulus and observation signals
  // ****************************************
  logic                  i_core_clk;
  logic                  i_rst;
  logic                  i_ce;
  aat_pkg::aat_instr_type i_instr;
  logic [9:0]            i_rom_word;
  logic [3:0]            i_rom_page_ctrl;
  logic [7:0][3:0]       i_port_in;
  logic [3:0]            i_status;
  logic                  i_wake;
  logic [3:0]            o_acc;
  logic                  o_carry_bit;
  logic                  o_match;
  aat_pkg::aat_tmr_type  o_tmr;
  logic [11:0]           o_rom_addr;
  logic                  o_standby;
  logic [3:0]            o_standby_cond;
  logic                  o_internal_reset;
  logic                  o_done;
  int                    n_mismatch;
  int                    checks_done;
  int                    cyc;
  int                    op, s, k, m, sl, t, a_i;
  logic                  irq_seen;
  logic [7:0]            base;
  logic [15:0]           w1;
  logic [3:0]            a, b;
  logic [4:0]            r;
  logic [9:0]            rw, d;
  logic [15:0]           tc [6][3];

  aat_datapath dut (
    .i_core_clk       (i_core_clk),
    .i_rst            (i_rst),
    .i_ce             (i_ce),
    .i_instr          (i_instr),
    .i_rom_word       (i_rom_word),
    .i_rom_page_ctrl  (i_rom_page_ctrl),
    .i_port_in        (i_port_in),
    .i_status         (i_status),
    .i_wake           (i_wake),
    .o_acc            (o_acc),
    .o_carry_bit      (o_carry_bit),
    .o_match          (o_match),
    .o_tmr            (o_tmr),
    .o_rom_addr       (o_rom_addr),
    .o_standby        (o_standby),
    .o_standby_cond   (o_standby_cond),
    .o_internal_reset (o_internal_reset),
    .o_done           (o_done)
  );

  // ****************************************
  // Clock, program memory and timeout
  // ****************************************
  // Program memory answers combinationally; bits 9:8 differ from 7:0 so ignored bits are exercised.
  function automatic logic [9:0] rom_fn(input logic [11:0] ad);
    return {ad[11:10] ^ ad[1:0], ad[7:0] ^ 8'h9c};
  endfunction
  assign i_rom_word = rom_fn(o_rom_addr);
  always #12.5 i_core_clk = ~i_core_clk;
  // A hang is cut short well beyond the roughly 600 cycles the sequence needs.
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One beat of instruction and wake, then settle just past the taking edge.
  task automatic drv(input logic [15:0] c1, input logic [9:0] c2, input logic v, input logic wk);
    @(posedge i_core_clk);
    i_instr <= {v, c1, c2};
    i_wake  <= wk;
    @(posedge i_core_clk);
    i_instr <= '0;
    i_wake  <= 1'b0;
    #1;
  endtask
  task automatic ex(input logic [15:0] c1, input logic [9:0] c2);
    drv(c1, c2, 1'b1, 1'b0);
    chk(o_done, 1'b1);
    irq_seen = o_internal_reset;
  endtask
  task automatic setacc(input logic [3:0] v);
    ex(16'hfff1, {6'h00, v});
  endtask
  // Leaves A at zero with carry set, so a carry clear is visible.
  task automatic setcy();
    setacc(4'hf);
    ex(aat_pkg::C_INC, 10'h000);
  endtask
  function automatic logic [4:0] alu(input int o, input logic [3:0] x, input logic [3:0] y);
    case (o)
      0:       return {x[3] & y[3], x & y};
      1:       return {1'b0, x | y};
      default: return {x[3] & y[3], x ^ y};
    endcase
  endfunction
  function automatic logic [9:0] treg(input int j);
    return (j == 0) ? o_tmr.timer : (j == 1) ? o_tmr.mod0 : o_tmr.mod1;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    i_core_clk = 1'b0; i_rst = 1'b1; i_ce = 1'b1; i_instr = '0; i_wake = 1'b0;
    i_rom_page_ctrl = 4'h2; i_status = 4'h6; n_mismatch = 0; checks_done = 0; cyc = 0;
    for (int i = 0; i < 8; i++) i_port_in[i] = 4'(9 + 5 * i);
    tc = '{'{16'he6ff, 16'he6f6, 16'he6f7}, '{16'hfeff, 16'hfef6, 16'hfef7}, '{16'hffff, 16'hfff6, 16'hfff7},
           '{16'he5ff, 16'he5f6, 16'he5f7}, '{16'hf4ff, 16'he4f6, 16'he4f7}, '{16'he7ff, 16'he7f6, 16'he7f7}};
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    #1;
    chk(o_acc, 4'h0);
    chk(o_standby, 1'b0);
    // Pointer pair 37 on page 2, register nibbles for the operand table.
    setacc(4'h7); ex(16'he5e0, 10'h000); setacc(4'h3); ex(16'he4e0, 10'h000);
    setacc(4'hc); ex(16'he5e5, 10'h000); setacc(4'h9); ex(16'he4e5, 10'h000);
    chk(o_rom_addr, 12'h237);
    rw = rom_fn(12'h237);
    // Every logic op against every operand source, with carry preset to one in half the cases.
    for (op = 0; op < 3; op++) for (s = 0; s < 6; s++) for (k = 0; k < 2; k++) begin
      base = (op == 0) ? 8'hfa : (op == 1) ? 8'hfc : 8'hf4;
      case (s)
        0: begin w1 = {base | 8'h01, 8'he5}; b = 4'hc; end
        1: begin w1 = {base, 8'he5}; b = 4'h9; end
        2: begin w1 = {base | 8'h01, 8'hf1}; b = 4'hd; end
        3: begin w1 = {base, 8'hf0}; b = rw[7:4]; end
        4: begin w1 = {base | 8'h01, 8'hf0}; b = rw[3:0]; end
        default: begin w1 = {base | 8'h01, 8'hfb}; b = i_port_in[2]; end
      endcase
      if (k == 1) begin
        a = 4'hb; setacc(4'hd); ex(aat_pkg::C_ROT, 10'h000);
      end else begin
        a = 4'h6; setacc(a);
      end
      ex(w1, 10'h3fd);
      r = alu(op, a, b);
      chk(o_acc, r[3:0]);
      chk(o_carry_bit, r[4]);
    end
    // Port reads from both halves of every port.
    for (m = 0; m < 2; m++) for (sl = 0; sl < 4; sl++) begin
      setcy();
      ex({m ? 8'hfe : 8'hff, 8'hf8 + 8'((sl < 2) ? sl : sl + 1)}, 10'h000);
      chk(o_acc, i_port_in[m * 4 + sl]);
      chk(o_carry_bit, 1'b0);
    end
    // Increment, both rotates and the all-ones test over every accumulator value.
    for (a_i = 0; a_i < 16; a_i++) for (t = 0; t < 4; t++) begin
      a = 4'(a_i);
      setacc(a);
      w1 = (t == 0) ? aat_pkg::C_INC : (t == 1) ? aat_pkg::C_ROT : (t == 2) ? aat_pkg::C_ROTZ : aat_pkg::C_ONES;
      ex(w1, 10'h000);
      r = (t == 0) ? {a == 4'hf, a + 4'h1} : (t == 3) ? {a == 4'hf, a} : {a[3], a[2:0], a[3]};
      chk(o_acc, r[3:0]);
      chk(o_carry_bit, r[4]);
      chk(irq_seen, t == 2 && a == 4'h0);
    end
    // Timer and modulo registers: immediate load, nibble reads, nibble writes, table load.
    for (k = 0; k < 3; k++) begin
      d = 10'h2b5 ^ 10'(k * 123);
      ex(tc[0][k], d);
      chk(treg(k), d);
      setcy(); ex(tc[1][k], 10'h000);
      chk(o_acc, d[9:6]);
      chk(o_carry_bit, 1'b0);
      setcy(); ex(tc[2][k], 10'h000);
      chk(o_acc, d[5:2]);
      chk(o_carry_bit, 1'b0);
      setcy(); ex(tc[3][k], 10'h000);
      chk(treg(k), {d[9:6], 4'h0, d[1:0]});
      chk(o_carry_bit, 1'b0);
      setacc(4'h5); ex(tc[4][k], 10'h000);
      chk(treg(k), {4'h5, 4'h0, d[1:0]});
      ex(tc[5][k], 10'h000);
      chk(treg(k), rw);
    end
    // Status compare, immediate and register forms, match and miss.
    ex(aat_pkg::C_STATUS_COMPARE_I, 10'h006); chk(o_match, 1'b1);
    ex(aat_pkg::C_STATUS_COMPARE_I, 10'h007); chk(o_match, 1'b0);
    setacc(4'h6); ex(16'he5ea, 10'h000); ex(16'he3ea, 10'h000); chk(o_match, 1'b1);
    ex(16'he3e5, 10'h000); chk(o_match, 1'b0);
    // Back-to-back increments across the wrap.
    setacc(4'he);
    @(posedge i_core_clk); i_instr <= {1'b1, aat_pkg::C_INC, 10'h000};
    @(posedge i_core_clk);
    @(posedge i_core_clk); i_instr <= '0;
    #1;
    chk(o_acc, 4'h0);
    chk(o_carry_bit, 1'b1);
    // Standby ignores instructions until woken.
    setacc(4'h2);
    ex(aat_pkg::C_STANDBY, 10'h009);
    chk(o_standby, 1'b1);
    chk(o_standby_cond, 4'h9);
    drv(16'hfff1, 10'h005, 1'b1, 1'b0);
    chk(o_done, 1'b0);
    chk(o_acc, 4'h2);
    drv(16'h0000, 10'h000, 1'b0, 1'b1);
    chk(o_standby, 1'b0);
    // A held-off clock enable freezes the datapath.
    @(posedge i_core_clk); i_ce <= 1'b0;
    drv(aat_pkg::C_INC, 10'h000, 1'b1, 1'b0);
    chk(o_done, 1'b0);
    chk(o_acc, 4'h2);
    @(posedge i_core_clk); i_ce <= 1'b1;
    // Reset in mid-run clears loaded registers.
    @(posedge i_core_clk); i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    #1;
    chk(o_acc, 4'h0);
    chk(o_tmr.mod1, 10'h000);
    complete_run();
  end

endmodule
`default_nettype wire
